// >>> rtl/kms_consts.svh
// constants of the keyboard matrix scan block
//------------------------------------------------------------------
// Behaviour
//------------------------------------------------------------------
// Behaviour
// [R1] scan disable set turns off all eighteen row drivers whatever else is set
// [R2] enabled, not inverted, single row: selected row low, the others high
// [R3] enabled, inverted, single row: selected row high, the others low
// [R4] select 18 to 31 picks no row: all high, or all low when inverted
// [R5] drive-all set: every row low, or every row high when inverted
// [R6] column level register at 8h returns the eight column levels in bits 7..0
// [R7] a falling edge on any column sets that column's edge flag
// [R8] writing 1 clears an edge flag, writing 0 leaves it alone
// [R9] a column interrupt is its edge flag and its enable both set
// [R10] runtime and wake interrupts are both the OR of column interrupts
// [R11] each enable bit at 10h gates its column's interrupt
// [R12] runtime interrupt rearms only when all columns high or row select changes
// [R13] with bus clock stopped an enabled falling edge raises wake until clock runs
// [R14] bits 31..8 of level, flag and enable registers read zero, writes ignored
`ifndef KMS_CONSTS_SVH
`define KMS_CONSTS_SVH

//------------------------------------------------------------------
// register offsets (byte addresses)
//------------------------------------------------------------------
`define KMS_OFS_ROW_CTRL   8'h04
`define KMS_OFS_COL_LEVEL  8'h08
`define KMS_OFS_COL_FLAG   8'h0c
`define KMS_OFS_COL_IRQEN  8'h10

//------------------------------------------------------------------
// row drive control fields and reset values
//------------------------------------------------------------------
`define KMS_CTRL_INV_BIT   7
`define KMS_CTRL_DIS_BIT   6
`define KMS_CTRL_ALL_BIT   5
`define KMS_CTRL_SEL_MSB   4
`define KMS_CTRL_RESET     8'h40
`define KMS_COL_RESET      8'h00

//------------------------------------------------------------------
// sizes
//------------------------------------------------------------------
`define KMS_ROWS           18
`define KMS_COLS           8
`define KMS_ROW_LAST       5'h11

`endif

// >>> rtl/kms_pkg.sv
// types shared by the keyboard matrix scan block
`include "kms_consts.svh"
package kms_pkg;

  typedef logic [`KMS_ROWS-1:0] kms_rows_t;
  typedef logic [`KMS_COLS-1:0] kms_cols_t;

  // whole state of the top module
  typedef struct packed {
    logic [7:0]  ctrl;       // row drive control
    kms_cols_t   irq_en;     // per-column interrupt enable
    kms_cols_t   flag;       // sticky falling-edge flags
    kms_cols_t   col_prev;   // last synchronised column levels
    kms_cols_t   wake_seen;  // last synchronised wake flags
    logic        armed;      // runtime interrupt may fire
    logic        irq_prev;   // runtime interrupt last cycle
    logic        wake_clr;   // clears the clockless wake capture
    logic [31:0] rdata;      // read data
    logic        rvalid;     // read answer strobe
    kms_rows_t   rows;       // row levels
    kms_rows_t   rows_oe;    // row output enables
  } kms_state_t;

endpackage

// >>> rtl/kms_sync.sv
// two-flop synchroniser, also used to release the reset
`timescale 1ns/1ps
module kms_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             nrst_in,
  // data
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);
  import kms_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } kms_sync_t;

  kms_sync_t st_q;
  kms_sync_t st_d;

  // first stage feeds only the second stage
  always_comb begin
    st_d    = st_q;
    st_d.s1 = d_in;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign q_out = st_q.s2;
endmodule

// >>> rtl/kms_wake_capture.sv
// clockless capture of column falling edges while the bus clock is stopped
`timescale 1ns/1ps
`include "kms_consts.svh"
module kms_wake_capture (
  // control from the bus clock domain
  input  wire logic                 arm_in,
  input  wire logic                 clr_in,
  // raw column pins
  input  wire logic [`KMS_COLS-1:0] col_raw_in,
  // captured edges
  output logic      [`KMS_COLS-1:0] flag_out
);
  import kms_pkg::*;

  // each column clocks its own flop; the pin edge is the only clock there is
  // during sleep, so this cannot be folded into the bus clock state
  // one private flop per column keeps each process the single writer of its own bit
  for (genvar i = 0; i < `KMS_COLS; i++) begin : g_col
    logic hit_q;
    always_ff @(negedge col_raw_in[i] or posedge clr_in) begin
      if (clr_in) begin
        hit_q <= 1'b0;
      end else begin
        hit_q <= arm_in; // R13
      end
    end
    assign flag_out[i] = hit_q;
  end
endmodule

// >>> rtl/kms_top.sv
// keyboard matrix scan: row drivers, column sensing, edge flags, interrupts
`timescale 1ns/1ps
`include "kms_consts.svh"
module kms_top (
  // clock and reset
  input  wire logic                clk_in,
  input  wire logic                nrst_in,
  // register port
  input  wire logic [7:0]          reg_addr_in,
  input  wire logic                reg_wr_in,
  input  wire logic                reg_rd_in,
  input  wire logic [31:0]         reg_wdata_in,
  output logic      [31:0]         reg_rdata_out,
  output logic                     reg_rvalid_out,
  // power management
  input  wire logic                sleep_en_in,
  output logic                     clk_req_out,
  // matrix pins
  output kms_pkg::kms_rows_t       row_scan_out,
  output kms_pkg::kms_rows_t       row_scan_oe_out,
  input  wire kms_pkg::kms_cols_t  column_sense_in,
  // interrupts
  output logic                     scan_runtime_irq_out,
  output logic                     scan_wake_irq_out
);
  import kms_pkg::*;

  //------------------------------------------------------------------
  // helpers
  //------------------------------------------------------------------
  // row levels for a control byte; disable only touches the enables
  function automatic kms_rows_t row_levels(input logic [7:0] c);
    kms_rows_t  lv;
    logic       inv;
    logic [4:0] sel;
    inv = c[`KMS_CTRL_INV_BIT];
    sel = c[`KMS_CTRL_SEL_MSB:0];
    lv  = {`KMS_ROWS{~inv}};                          // R4
    if (c[`KMS_CTRL_ALL_BIT]) begin
      lv = {`KMS_ROWS{inv}};                          // R5
    end else if (sel <= `KMS_ROW_LAST) begin
      lv[sel] = inv;                                  // R2 R3
    end
    return lv;
  endfunction

  //------------------------------------------------------------------
  // reset release and input synchronisers
  //------------------------------------------------------------------
  logic       rst_n;
  kms_cols_t  col_sync;
  kms_cols_t  wake_raw;
  kms_cols_t  wake_sync;
  logic       wake_clr_async;

  kms_sync #(.WIDTH(1)) u_rst_sync (
    .clk_in  (clk_in),
    .nrst_in (nrst_in),
    .d_in    (1'b1),
    .q_out   (rst_n)
  );

  // column pins are asynchronous; two flops before any logic but the clockless wake capture looks at them
  kms_sync #(.WIDTH(`KMS_COLS)) u_col_sync (
    .clk_in  (clk_in),
    .nrst_in (rst_n),
    .d_in    (column_sense_in),
    .q_out   (col_sync)
  );

  kms_state_t st_q;
  kms_state_t st_d;

  // capture held clear whenever sleep is off and no unsynchronised capture is pending, or reset is active
  assign wake_clr_async = ~rst_n | st_q.wake_clr;

  kms_wake_capture u_wake (
    .arm_in     (sleep_en_in),
    .clr_in     (wake_clr_async),
    .col_raw_in (column_sense_in),
    .flag_out   (wake_raw)
  );

  kms_sync #(.WIDTH(`KMS_COLS)) u_wake_sync (
    .clk_in  (clk_in),
    .nrst_in (rst_n),
    .d_in    (wake_raw),
    .q_out   (wake_sync)
  );

  //------------------------------------------------------------------
  // next state
  //------------------------------------------------------------------
  logic      wr_ctrl;
  logic      wr_flag;
  logic      wr_en;
  kms_cols_t col_irq;
  logic      any_irq;
  logic      run_irq;

  assign wr_ctrl = reg_wr_in && (reg_addr_in == `KMS_OFS_ROW_CTRL);
  assign wr_flag = reg_wr_in && (reg_addr_in == `KMS_OFS_COL_FLAG);
  assign wr_en   = reg_wr_in && (reg_addr_in == `KMS_OFS_COL_IRQEN);

  // per-column interrupts from registered flag and enable
  assign col_irq = st_q.flag & st_q.irq_en;         // R9 R11
  assign any_irq = |col_irq;
  assign run_irq = any_irq & st_q.armed;

  always_comb begin
    st_d = st_q;
    // control and enable writes; upper bits dropped
    if (wr_ctrl) begin
      st_d.ctrl = reg_wdata_in[7:0];
    end
    if (wr_en) begin
      st_d.irq_en = reg_wdata_in[`KMS_COLS-1:0];    // R14
    end
    // flags: set beats clear so an edge in the clearing cycle survives
    st_d.flag = st_q.flag;
    if (wr_flag) begin
      st_d.flag = st_q.flag & ~reg_wdata_in[`KMS_COLS-1:0]; // R8
    end
    st_d.flag = st_d.flag | (st_q.col_prev & ~col_sync);   // R7
    st_d.flag = st_d.flag | (wake_sync & ~st_q.wake_seen); // R13
    st_d.col_prev  = col_sync;
    st_d.wake_seen = wake_sync;
    // wake capture released only once its edge has reached the flags
    st_d.wake_clr = ~sleep_en_in & (|wake_sync | ~|wake_raw);
    // runtime interrupt rearm
    st_d.irq_prev = run_irq;
    if (st_q.irq_prev && !run_irq) begin
      st_d.armed = 1'b0;                            // R12
    end
    if (&col_sync || (wr_ctrl &&
        reg_wdata_in[`KMS_CTRL_SEL_MSB:0] != st_q.ctrl[`KMS_CTRL_SEL_MSB:0])) begin
      st_d.armed = 1'b1;                            // R12
    end
    // read answer, one cycle after the strobe
    st_d.rvalid = reg_rd_in;
    st_d.rdata  = 32'h0000_0000;
    if (reg_rd_in) begin
      if (reg_addr_in == `KMS_OFS_ROW_CTRL) begin
        st_d.rdata = {24'h00_0000, st_q.ctrl};
      end else if (reg_addr_in == `KMS_OFS_COL_LEVEL) begin
        st_d.rdata = {24'h00_0000, col_sync};       // R6 R14
      end else if (reg_addr_in == `KMS_OFS_COL_FLAG) begin
        st_d.rdata = {24'h00_0000, st_q.flag};      // R14
      end else if (reg_addr_in == `KMS_OFS_COL_IRQEN) begin
        st_d.rdata = {24'h00_0000, st_q.irq_en};    // R14
      end else begin
        st_d.rdata = 32'h0000_0000;
      end
    end
    // row drivers from the control value now in force
    st_d.rows    = row_levels(st_d.ctrl);
    st_d.rows_oe = {`KMS_ROWS{~st_d.ctrl[`KMS_CTRL_DIS_BIT]}}; // R1
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      st_q          <= '0;
      st_q.ctrl     <= `KMS_CTRL_RESET;
      st_q.armed    <= 1'b1;
      st_q.wake_clr <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  //------------------------------------------------------------------
  // outputs
  //------------------------------------------------------------------
  assign reg_rdata_out        = st_q.rdata;
  assign reg_rvalid_out       = st_q.rvalid;
  assign row_scan_out         = st_q.rows;
  assign row_scan_oe_out      = st_q.rows_oe;
  assign clk_req_out          = ~sleep_en_in;
  assign scan_runtime_irq_out = run_irq;                            // R10
  // wake also takes the clockless capture so it works with no clock
  assign scan_wake_irq_out    = any_irq | (|(wake_raw & st_q.irq_en)); // R10 R13

  //------------------------------------------------------------------
  // assertions
  //------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n);

  sequence s_flag_write;
    wr_flag ##1 1'b1;
  endsequence

  row_disable_a: assert property ( // R1
    st_q.ctrl[`KMS_CTRL_DIS_BIT] |-> row_scan_oe_out == '0)
    else $error("rows driven while scan disabled");
  row_single_a: assert property ( // R2
    (st_q.ctrl[7:5] == 3'b000 && st_q.ctrl[4:0] <= `KMS_ROW_LAST) |->
      row_scan_out == ~(kms_rows_t'(1) << st_q.ctrl[4:0]))
    else $error("normal single row pattern wrong");
  row_inv_a: assert property ( // R3
    (st_q.ctrl[7:5] == 3'b100 && st_q.ctrl[4:0] <= `KMS_ROW_LAST) |->
      row_scan_out == (kms_rows_t'(1) << st_q.ctrl[4:0]))
    else $error("inverted single row pattern wrong");
  row_none_a: assert property ( // R4
    (!st_q.ctrl[5] && st_q.ctrl[4:0] > `KMS_ROW_LAST) |->
      row_scan_out == {`KMS_ROWS{~st_q.ctrl[7]}})
    else $error("no-row select pattern wrong");
  row_all_a: assert property ( // R5
    st_q.ctrl[5] |-> row_scan_out == {`KMS_ROWS{st_q.ctrl[7]}})
    else $error("drive-all pattern wrong");
  level_read_a: assert property ( // R6
    (reg_rd_in && reg_addr_in == `KMS_OFS_COL_LEVEL) |=>
      reg_rvalid_out && reg_rdata_out == {24'h00_0000, $past(col_sync)})
    else $error("column level read wrong");
  edge_set_a: assert property ( // R7
    (st_q.col_prev[0] && !col_sync[0]) |=> st_q.flag[0])
    else $error("falling edge did not set flag");
  flag_clear_a: assert property ( // R8
    s_flag_write |-> ((st_q.flag & $past(reg_wdata_in[7:0])) ==
      ($past(st_q.col_prev & ~col_sync | wake_sync & ~st_q.wake_seen)
       & $past(reg_wdata_in[7:0]))))
    else $error("written flag not cleared");
  wake_or_a: assert property ( // R10
    any_irq |-> scan_wake_irq_out)
    else $error("wake missing column interrupt");
  irq_gate_a: assert property ( // R9
    scan_runtime_irq_out |-> |(st_q.flag & st_q.irq_en))
    else $error("runtime interrupt without enabled flag");
  rearm_a: assert property ( // R12
    ($fell(run_irq) && !(&col_sync) && !wr_ctrl) |=> !st_q.armed)
    else $error("runtime interrupt rearmed too early");
  upper_zero_a: assert property ( // R14
    reg_rvalid_out |-> reg_rdata_out[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");

  //------------------------------------------------------------------
  // register port, gating and rearm assertions
  //------------------------------------------------------------------
  // a control write that moves the row select, the second rearm condition
  sequence s_sel_change;
    wr_ctrl && (reg_wdata_in[`KMS_CTRL_SEL_MSB:0] != st_q.ctrl[`KMS_CTRL_SEL_MSB:0]);
  endsequence

  // a read strobe answered on the very next cycle
  sequence s_read_answer;
    reg_rd_in ##1 reg_rvalid_out;
  endsequence

  read_answer_a: assert property ( // R6
    reg_rd_in |-> s_read_answer)
    else $error("read strobe not answered");
  read_quiet_a: assert property ( // R6
    !reg_rd_in |=> !reg_rvalid_out)
    else $error("answer without a read strobe");
  idle_data_a: assert property ( // R14
    !reg_rvalid_out |-> reg_rdata_out == 32'h0000_0000)
    else $error("read data not zero between answers");
  ctrl_write_a: assert property ( // R1
    wr_ctrl |=> st_q.ctrl == $past(reg_wdata_in[7:0]))
    else $error("control write lost");
  row_enable_a: assert property ( // R1
    !st_q.ctrl[`KMS_CTRL_DIS_BIT] |-> row_scan_oe_out == {`KMS_ROWS{1'b1}})
    else $error("rows not driven while scan enabled");
  en_write_a: assert property ( // R11
    wr_en |=> st_q.irq_en == $past(reg_wdata_in[`KMS_COLS-1:0]))
    else $error("enable write lost");
  // flags only fall through a write, and only where a one was written
  flag_hold_a: assert property ( // R8
    !wr_flag |=> ($past(st_q.flag) & ~st_q.flag) == '0)
    else $error("flag cleared without a write");
  flag_keep_a: assert property ( // R8
    wr_flag |=> ($past(st_q.flag & ~reg_wdata_in[`KMS_COLS-1:0]) & ~st_q.flag) == '0)
    else $error("flag written with zero was cleared");
  runtime_or_a: assert property ( // R10
    (any_irq && st_q.armed) |-> scan_runtime_irq_out)
    else $error("runtime interrupt missing");
  en_gate_a: assert property ( // R11
    ((st_q.flag & st_q.irq_en) == '0) |-> !scan_runtime_irq_out)
    else $error("runtime interrupt from a masked column");
  rearm_cols_a: assert property ( // R12
    (&col_sync) |=> st_q.armed)
    else $error("not rearmed with all columns high");
  rearm_sel_a: assert property ( // R12
    s_sel_change |=> st_q.armed)
    else $error("not rearmed on select change");
  // the clockless path may only speak for an enabled column
  wake_gate_a: assert property ( // R13
    scan_wake_irq_out |-> |((st_q.flag | wake_raw) & st_q.irq_en))
    else $error("wake interrupt from a masked column");
  wake_clear_a: assert property ( // R13
    st_q.wake_clr |-> wake_raw == '0)
    else $error("wake capture not cleared while awake");
  clk_req_a: assert property (
    clk_req_out != sleep_en_in)
    else $error("clock request not inverse of sleep");

  // every column, not only the first, must latch its own falling edge
  for (genvar c = 0; c < `KMS_COLS; c++) begin : g_edge_chk
    edge_each_a: assert property ( // R7
      (st_q.col_prev[c] && !col_sync[c]) |=> st_q.flag[c])
      else $error("falling edge did not set its flag");
  end
endmodule

// >>> dv/kms_key_matrix.sv
// behavioural keyboard switch matrix between row drivers and column inputs
`timescale 1ns/1ps
module kms_key_matrix (
  // row pins from the scanner
  input  wire logic [17:0]      row_scan_in,
  input  wire logic [17:0]      row_scan_oe_in,
  // pressed keys, one row mask per column
  input  wire logic [7:0][17:0] key_down_in,
  // column pins back to the scanner
  output logic      [7:0]       column_sense_out
);
  logic [17:0] row_wire;

  // an undriven row floats up to its pull-up, never a stale low
  assign row_wire = ~row_scan_oe_in | row_scan_in;

  // a column is pulled low only through a pressed key on a low row
  always_comb begin
    for (int c = 0; c < 8; c++) begin
      column_sense_out[c] = ~|(key_down_in[c] & ~row_wire);
    end
  end
endmodule

// >>> dv/test_keyboard_matrix_scan.sv
// self-checking bench for the keyboard matrix scan block
`timescale 1ns/1ps
module test_keyboard_matrix_scan;
  import kms_pkg::*;
  logic             clk_in = 1'b0;
  logic             clk_run = 1'b1;
  logic             nrst_in = 1'b0;
  logic [7:0]       reg_addr_in = 8'h00;
  logic             reg_wr_in = 1'b0;
  logic             reg_rd_in = 1'b0;
  logic [31:0]      reg_wdata_in = 32'h0;
  logic [31:0]      reg_rdata_out;
  logic             reg_rvalid_out;
  logic             sleep_en_in = 1'b0;
  logic             clk_req_out;
  kms_rows_t        row_scan_out;
  kms_rows_t        row_scan_oe_out;
  kms_cols_t        column_sense_in;
  logic             scan_runtime_irq_out;
  logic             scan_wake_irq_out;
  logic [7:0][17:0] keys = '0;
  int               err_total = 0;
  int               n_compared = 0;

  // a stopped clock rests low, as the bus clock does in sleep
  always #4 clk_in = clk_run ? ~clk_in : clk_in;

  kms_top i_dut (
    .clk_in(clk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
    .sleep_en_in(sleep_en_in), .clk_req_out(clk_req_out),
    .row_scan_out(row_scan_out), .row_scan_oe_out(row_scan_oe_out),
    .column_sense_in(column_sense_in), .scan_runtime_irq_out(scan_runtime_irq_out),
    .scan_wake_irq_out(scan_wake_irq_out)
  );

  kms_key_matrix i_keys (
    .row_scan_in(row_scan_out), .row_scan_oe_in(row_scan_oe_out),
    .key_down_in(keys), .column_sense_out(column_sense_in)
  );

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one write strobe, held over exactly one sampling edge
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
    #1;
  endtask

  // the answer stands for one cycle only, so it is taken right after the edge
  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1;
    chk("rvalid", 32'h1, {31'h0, reg_rvalid_out});
    chk("rdata", e, reg_rdata_out);
  endtask

  // key change, then time for the two-flop column path to land
  task automatic key(int r, int c, logic v);
    @(posedge clk_in);
    keys[c][r] <= v;
    repeat (4) @(posedge clk_in);
    #1;
  endtask

  task automatic irqs(logic rt, logic wk);
    chk("runtime irq", {31'h0, rt}, {31'h0, scan_runtime_irq_out});
    chk("wake irq", {31'h0, wk}, {31'h0, scan_wake_irq_out});
  endtask

  function automatic logic [17:0] exp_rows(logic [7:0] c);
    logic [17:0] r;
    r = c[5] ? 18'h0 : (c[4:0] < 5'h12 ? ~(18'h1 << c[4:0]) : 18'h3ffff);
    return c[7] ? ~r : r;
  endfunction

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // hang guard, about a hundred times the length of the whole run
  initial begin
    #500000;
    err_total++;
    $display("BAD watchdog expected finish seen hang");
    close_out();
  end

  initial begin
    repeat (5) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    #1;
    chk("row oe", 32'h0, {14'h0, row_scan_oe_out});
    rd(`KMS_OFS_ROW_CTRL, 32'h40);
    rd(`KMS_OFS_COL_LEVEL, 32'hff);
    rd(`KMS_OFS_COL_FLAG, 32'h0);
    rd(`KMS_OFS_COL_IRQEN, 32'h0);
    rd(8'h14, 32'h0);
    $display("test reset finished");
    // every control value, reserved selects and disable included
    for (int i = 0; i < 256; i++) begin
      wr(`KMS_OFS_ROW_CTRL, 32'(i));
      chk("row oe", i[6] ? 32'h0 : 32'h3ffff, {14'h0, row_scan_oe_out});
      if (!i[6]) chk("rows", {14'h0, exp_rows(i[7:0])}, {14'h0, row_scan_out});
    end
    $display("test row decode finished");
    wr(`KMS_OFS_ROW_CTRL, 32'h02);
    wr(`KMS_OFS_COL_IRQEN, 32'hffffff00);
    rd(`KMS_OFS_COL_IRQEN, 32'h0);
    key(2, 5, 1'b1);
    rd(`KMS_OFS_COL_LEVEL, 32'hdf);
    rd(`KMS_OFS_COL_FLAG, 32'h20);
    irqs(1'b0, 1'b0);
    wr(`KMS_OFS_COL_IRQEN, 32'h20);
    irqs(1'b1, 1'b1);
    key(2, 1, 1'b1);
    rd(`KMS_OFS_COL_FLAG, 32'h22);
    wr(`KMS_OFS_COL_FLAG, 32'hdd);
    rd(`KMS_OFS_COL_FLAG, 32'h22);
    wr(`KMS_OFS_COL_FLAG, 32'h20);
    rd(`KMS_OFS_COL_FLAG, 32'h02);
    irqs(1'b0, 1'b0);
    // columns still low and select unchanged: no second runtime interrupt
    wr(`KMS_OFS_COL_IRQEN, 32'h22);
    chk("runtime irq", 32'h0, {31'h0, scan_runtime_irq_out});
    wr(`KMS_OFS_ROW_CTRL, 32'h03);
    chk("runtime irq", 32'h1, {31'h0, scan_runtime_irq_out});
    $display("test column events finished");
    @(posedge clk_in);
    keys <= '0;
    wr(`KMS_OFS_ROW_CTRL, 32'h00);
    wr(`KMS_OFS_COL_IRQEN, 32'h01);
    repeat (4) @(posedge clk_in);
    wr(`KMS_OFS_COL_FLAG, 32'hff);
    irqs(1'b0, 1'b0);
    @(posedge clk_in);
    sleep_en_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    clk_run = 1'b0;
    #1;
    chk("clk req", 32'h0, {31'h0, clk_req_out});
    #10 keys[0][0] = 1'b1;
    #20;
    chk("wake irq", 32'h1, {31'h0, scan_wake_irq_out});
    clk_run = 1'b1;
    @(posedge clk_in);
    sleep_en_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    #1;
    chk("clk req", 32'h1, {31'h0, clk_req_out});
    rd(`KMS_OFS_COL_FLAG, 32'h01);
    $display("test wake finished");
    close_out();
  end
endmodule
